// ===== hw/crf_core_regs.sv
// architectural register set of the 8-bit core
// assumes a decoder drives op_i and friends for one cycle per instruction
`timescale 1ns/1ns
`default_nettype none
module crf_core_regs
  import crf_pkg::*;
#(
  parameter int PC_WIDTH = 16,
  parameter int PROG_BYTES = 8192
) (
  input  wire logic        clk_i,         // core clock, 25 MHz
  input  wire logic        reset_i,       // synchronous, active high
  input  wire crf_op_e     op_i,          // operation this cycle
  input  wire crf_dst_e    dst_i,         // destination register
  input  wire logic [2:0]  alu_func_i,    // alu function select
  input  wire logic        src_is_imm_i,  // second operand is operand byte
  input  wire logic [7:0]  operand_i,     // instruction operand byte
  input  wire logic [7:0]  mem_data_i,    // data read from memory
  input  wire logic        pc_inc_i,      // advance program counter
  input  wire logic [1:0]  pc_step_i,     // bytes of current instruction
  input  wire logic        pc_load_i,     // jump or call target load
  input  wire logic [15:0] pc_target_i,   // jump target
  input  wire logic        super_i,       // supervisor code running
  input  wire logic [7:0]  reg_addr_i,    // register space read address
  output logic      [7:0]  reg_rdata_o,   // register space read data
  output logic             reg_hit_o,     // read address is the flags
  output logic      [7:0]  acc_o,         // accumulator
  output logic      [7:0]  index_o,       // index register
  output logic      [7:0]  sp_o,          // stack pointer
  output logic      [7:0]  pc_low_o,      // program counter bits 7..0
  output logic      [7:0]  pc_high_o,     // program counter bits 15..8
  output logic      [7:0]  flags_o,       // flags register
  output logic      [7:0]  eff_addr_o,    // indexed effective address
  output logic             irq_enable_o,  // global interrupt enable
  output logic             bank_sel_o     // register bank select
);

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  if (PC_WIDTH != 16) begin : g_bad_pc_width
    $error("program counter must be 16 bits");
  end
  if (PROG_BYTES > (1 << PC_WIDTH)) begin : g_bad_prog_size
    $error("program memory exceeds counter reach");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] accumulator_reg;
  logic [7:0] index_reg;
  logic [7:0] stack_ptr_reg;
  logic [7:0] pc_low_byte_reg;
  logic [7:0] pc_high_byte_reg;
  logic       zero_reg;
  logic       carry_reg;
  logic       super_reg;
  logic       bank_select_reg;
  logic       global_irq_enable_reg;
  logic [7:0] eff_addr_reg;
  logic [7:0] rdata_reg;
  logic       hit_reg;

  logic [15:0] program_counter;
  logic [7:0]  flags_now;
  logic [7:0]  flags_next;
  logic [7:0]  src_b;
  logic        alu_write;

  crf_alu_if alu_bus ();

  crf_alu i_crf_alu (
    .bus (alu_bus)
  );

  assign program_counter = {pc_high_byte_reg, pc_low_byte_reg};

  // reserved bits 7..5 always read zero
  assign flags_now = {3'b000, bank_select_reg, super_reg, carry_reg,
                      zero_reg, global_irq_enable_reg};

  // ----------------------------------------------------------------------
  // alu operand selection
  // ----------------------------------------------------------------------
  always_comb begin
    src_b = src_is_imm_i ? operand_i : mem_data_i;
    case (dst_i)
      CRF_DST_A:  alu_bus.opnd_a = accumulator_reg;
      CRF_DST_X:  alu_bus.opnd_a = index_reg;
      CRF_DST_SP: alu_bus.opnd_a = stack_ptr_reg;
      CRF_DST_F:  alu_bus.opnd_a = flags_now;
      default:    alu_bus.opnd_a = accumulator_reg;
    endcase
  end

  assign alu_bus.opnd_b   = src_b;
  assign alu_bus.func     = alu_func_i;
  assign alu_bus.carry_in = carry_reg;
  assign alu_write        = (op_i == CRF_OP_ALU);

  // ----------------------------------------------------------------------
  // flag logic ops: or sets, and clears, supervisor bit protected
  // ----------------------------------------------------------------------
  always_comb begin
    case (op_i)
      CRF_OP_OR_F:  flags_next = flags_now | (operand_i & CRF_FLAGS_WMASK);
      CRF_OP_AND_F: flags_next = flags_now & (operand_i | ~CRF_FLAGS_WMASK);
      CRF_OP_XOR_F: flags_next = flags_now ^ (operand_i & CRF_FLAGS_WMASK);
      CRF_OP_RETURN_FROM_IRQ_OP:  flags_next = (mem_data_i & CRF_FLAGS_WMASK)
                                 | (flags_now & ~CRF_FLAGS_WMASK);
      default:      flags_next = flags_now;
    endcase
  end

  // ----------------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      accumulator_reg <= CRF_DATA_RESET;
    end else if (dst_i == CRF_DST_A && alu_write) begin
      accumulator_reg <= alu_bus.result;
    end else if (dst_i == CRF_DST_A && op_i == CRF_OP_LOAD) begin
      accumulator_reg <= src_b;
    end else if (op_i == CRF_OP_SWAP_SP) begin
      accumulator_reg <= stack_ptr_reg;
    end else if (op_i == CRF_OP_POP && dst_i == CRF_DST_A) begin
      accumulator_reg <= mem_data_i;
    end
  end

  // ----------------------------------------------------------------------
  // index register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      index_reg <= CRF_DATA_RESET;
    end else if (dst_i == CRF_DST_X && alu_write) begin
      index_reg <= alu_bus.result;
    end else if (dst_i == CRF_DST_X && op_i == CRF_OP_LOAD) begin
      index_reg <= src_b;
    end else if (op_i == CRF_OP_POP && dst_i == CRF_DST_X) begin
      index_reg <= mem_data_i;
    end
  end

  // operand byte plus index wraps inside the 256-byte data space
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      eff_addr_reg <= CRF_DATA_RESET;
    end else begin
      eff_addr_reg <= operand_i + index_reg;
    end
  end

  // ----------------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stack_ptr_reg <= CRF_DATA_RESET;
    end else begin
      case (op_i)
        CRF_OP_PUSH:    stack_ptr_reg <= stack_ptr_reg + 8'h01;
        CRF_OP_POP:     stack_ptr_reg <= stack_ptr_reg - 8'h01;
        CRF_OP_CALL:    stack_ptr_reg <= stack_ptr_reg + 8'h02;
        CRF_OP_RET:     stack_ptr_reg <= stack_ptr_reg - 8'h02;
        CRF_OP_RETURN_FROM_IRQ_OP:    stack_ptr_reg <= stack_ptr_reg - 8'h03;
        CRF_OP_SWAP_SP: stack_ptr_reg <= accumulator_reg;
        CRF_OP_ADD_SP:  stack_ptr_reg <= stack_ptr_reg + operand_i;
        CRF_OP_ALU: begin
          if (dst_i == CRF_DST_SP)
            stack_ptr_reg <= alu_bus.result;
        end
        CRF_OP_LOAD: begin
          if (dst_i == CRF_DST_SP)
            stack_ptr_reg <= src_b;
        end
        default: stack_ptr_reg <= stack_ptr_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // program counter, kept as two byte registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {pc_high_byte_reg, pc_low_byte_reg} <= CRF_PC_RESET;
    end else if (pc_load_i) begin
      {pc_high_byte_reg, pc_low_byte_reg} <= pc_target_i;
    end else if (pc_inc_i) begin
      {pc_high_byte_reg, pc_low_byte_reg} <=
        program_counter + {14'h0000, pc_step_i};
    end
  end

  // ----------------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      zero_reg  <= CRF_FLAGS_RESET[CRF_F_ZERO];
      carry_reg <= CRF_FLAGS_RESET[CRF_F_CARRY];
    end else if (alu_write && dst_i != CRF_DST_F) begin
      carry_reg <= alu_bus.carry_out;
      zero_reg  <= alu_bus.zero_out;
    end else begin
      carry_reg <= flags_next[CRF_F_CARRY];
      zero_reg  <= flags_next[CRF_F_ZERO];
    end
  end

  // ----------------------------------------------------------------------
  // control flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      global_irq_enable_reg <= CRF_FLAGS_RESET[CRF_F_GIE];
      bank_select_reg       <= CRF_FLAGS_RESET[CRF_F_BANK];
    end else begin
      global_irq_enable_reg <= flags_next[CRF_F_GIE];
      bank_select_reg       <= flags_next[CRF_F_BANK];
    end
  end

  // user flag writes are masked, so only the mode input moves this bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      super_reg <= CRF_FLAGS_RESET[CRF_F_SUPER];
    end else begin
      super_reg <= super_i;
    end
  end

  // ----------------------------------------------------------------------
  // register space read: only the flags answer, others stay hidden
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= CRF_DATA_RESET;
      hit_reg   <= 1'b0;
    end else if (reg_addr_i == CRF_FLAGS_ADDR) begin
      rdata_reg <= flags_now;
      hit_reg   <= 1'b1;
    end else begin
      rdata_reg <= CRF_DATA_RESET;
      hit_reg   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign reg_rdata_o  = rdata_reg;
  assign reg_hit_o    = hit_reg;
  assign acc_o        = accumulator_reg;
  assign index_o      = index_reg;
  assign sp_o         = stack_ptr_reg;
  assign pc_low_o     = pc_low_byte_reg;
  assign pc_high_o    = pc_high_byte_reg;
  assign flags_o      = flags_now;
  assign eff_addr_o   = eff_addr_reg;
  assign irq_enable_o = global_irq_enable_reg;
  assign bank_sel_o   = bank_select_reg;

endmodule : crf_core_regs
`default_nettype wire

// ===== include/crf_pkg.sv
// holds constants and types for the core register file
// assumes a single 25 MHz clock domain and synchronous active-high reset
//
// Overview of operation
// - five core registers change only through instructions, not register space
// - program counter is 16 bits, covering all of the 8 KB program memory
// - high counter byte is its own register, counter bits 15..8, reset zero
// - accumulator takes source-mode logic or arithmetic results aimed at it, reset zero
// - index register gives the offset for indexed modes, reset zero
// - stack pointer holds stack top, moved by push, pop, calls and returns
// - swap and add instructions may also change the stack pointer
// - zero at bit 1, carry bit 2, supervisor bit 3, bits 7..5 read zero
// - flag bit 0 is global interrupt enable, read-write, reset zero
// - carry flag shows whether the last logic or arithmetic op carried
// - zero flag shows a zero last result, and resets to one
// - supervisor bit is one in supervisor code, read-only to user writes
// - flag bit 4 picks register bank, user writable, reset zero
// - flags readable at 0xF7; or-flags sets bits, and-flags clears them
// - arithmetic, logic and shift ops update flags as each op defines
// - low counter byte is its own register, counter bits 7..0, reset zero
// - indexed effective address is operand byte plus index register
package crf_pkg;

  // ----------------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------------
  localparam logic [7:0] CRF_FLAGS_ADDR = 8'hF7;

  // ----------------------------------------------------------------------
  // flag field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CRF_F_GIE   = 0;
  localparam int CRF_F_ZERO  = 1;
  localparam int CRF_F_CARRY = 2;
  localparam int CRF_F_SUPER = 3;
  localparam int CRF_F_BANK  = 4;
  localparam logic [7:0] CRF_FLAGS_RESET = 8'h02;
  localparam logic [7:0] CRF_FLAGS_WMASK = 8'h17;
  localparam logic [7:0] CRF_DATA_RESET  = 8'h00;
  localparam logic [15:0] CRF_PC_RESET   = 16'h0000;

  // ----------------------------------------------------------------------
  // operation codes seen by the register file
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CRF_OP_NONE,
    CRF_OP_ALU,       // result and flags from alu
    CRF_OP_LOAD,      // plain move, no flag change
    CRF_OP_OR_F,      // or immediate into flags
    CRF_OP_AND_F,     // and immediate into flags
    CRF_OP_XOR_F,     // xor immediate into flags
    CRF_OP_PUSH,
    CRF_OP_POP,
    CRF_OP_CALL,      // push two return bytes
    CRF_OP_RET,       // pop two return bytes
    CRF_OP_RETURN_FROM_IRQ_OP,      // pop three bytes, flags restored
    CRF_OP_SWAP_SP,   // exchange accumulator and stack pointer
    CRF_OP_ADD_SP     // signed immediate added to stack pointer
  } crf_op_e;

  typedef enum logic [1:0] {
    CRF_DST_A,
    CRF_DST_X,
    CRF_DST_SP,
    CRF_DST_F
  } crf_dst_e;

endpackage : crf_pkg

// ===== include/crf_alu_if.sv
// carries operands and results between the register file and its alu
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface crf_alu_if;
  logic [7:0] opnd_a;
  logic [7:0] opnd_b;
  logic [2:0] func;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;
  logic       zero_out;

  modport core (output opnd_a, opnd_b, func, carry_in,
                input  result, carry_out, zero_out);
  modport alu  (input  opnd_a, opnd_b, func, carry_in,
                output result, carry_out, zero_out);
endinterface : crf_alu_if
`default_nettype wire

// ===== hw/crf_alu.sv
// combinational alu for arithmetic, logic and shift results
// assumes the register file captures its outputs on the next edge
`timescale 1ns/1ns
`default_nettype none
module crf_alu (
  crf_alu_if.alu bus   // operands in, result and flags out
);
  logic [8:0] sum;

  always_comb begin
    sum = 9'h000;
    case (bus.func)
      3'h0: sum = {1'b0, bus.opnd_a} + {1'b0, bus.opnd_b};
      3'h1: sum = {1'b0, bus.opnd_a} + {1'b0, bus.opnd_b}
                  + {8'h00, bus.carry_in};
      3'h2: sum = {1'b0, bus.opnd_a} - {1'b0, bus.opnd_b};
      3'h3: sum = {1'b0, bus.opnd_a & bus.opnd_b};
      3'h4: sum = {1'b0, bus.opnd_a | bus.opnd_b};
      3'h5: sum = {1'b0, bus.opnd_a ^ bus.opnd_b};
      3'h6: sum = {bus.opnd_a, 1'b0};                        // shift left
      3'h7: sum = {bus.opnd_a[0], bus.carry_in, bus.opnd_a[7:1]};
      default: sum = 9'h000;
    endcase
  end

  // carry is the ninth bit; logic ops never carry
  assign bus.result    = sum[7:0];
  assign bus.carry_out = sum[8];
  assign bus.zero_out  = (sum[7:0] == 8'h00);
endmodule : crf_alu
`default_nettype wire

// ===== tb/crf_core_regs_asserts.sv
// concurrent checks on the ports of the core register file
// assumes it is bound into crf_core_regs; one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module crf_core_regs_asserts
  import crf_pkg::*;
#(
  parameter int PC_WIDTH   = 16,
  parameter int PROG_BYTES = 8192
) (
  input wire logic        clk_i,        // core clock
  input wire logic        reset_i,      // sync reset
  input wire crf_op_e     op_i,         // operation
  input wire logic [7:0]  operand_i,    // operand byte
  input wire logic [7:0]  reg_addr_i,   // read address
  input wire logic        super_i,      // supervisor code
  input wire logic        pc_load_i,    // jump load
  input wire logic [15:0] pc_target_i,  // jump target
  input wire logic [7:0]  reg_rdata_o,  // read data
  input wire logic        reg_hit_o,    // read hit
  input wire logic [7:0]  acc_o,        // accumulator
  input wire logic [7:0]  index_o,      // index
  input wire logic [7:0]  sp_o,         // stack pointer
  input wire logic [7:0]  pc_low_o,     // counter low
  input wire logic [7:0]  pc_high_o,    // counter high
  input wire logic [7:0]  flags_o,      // flags
  input wire logic [7:0]  eff_addr_o,   // indexed address
  input wire logic        irq_enable_o, // interrupt enable
  input wire logic        bank_sel_o    // bank select
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_rst;
    $fell(reset_i) |-> acc_o == 8'h00 && index_o == 8'h00 && sp_o == 8'h00
      && {pc_high_o, pc_low_o} == 16'h0000 && flags_o == CRF_FLAGS_RESET;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
  // read data shows the flags as they stood at the address edge
  property p_rd_hit;
    reg_addr_i == CRF_FLAGS_ADDR
      |=> reg_hit_o && reg_rdata_o == $past(flags_o);
  endproperty
  a_rd_hit: assert property (p_rd_hit)
    else $error("flags read wrong");
  property p_rd_miss;
    reg_addr_i != CRF_FLAGS_ADDR |=> !reg_hit_o && reg_rdata_o == 8'h00;
  endproperty
  a_rd_miss: assert property (p_rd_miss)
    else $error("unmapped read not zero");
  property p_resv;
    flags_o[7:5] == 3'b000;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved flag bits set");
  property p_super;
    1'b1 |=> flags_o[CRF_F_SUPER] == $past(super_i);
  endproperty
  a_super: assert property (p_super)
    else $error("supervisor bit wrong");
  property p_out;
    op_i == CRF_OP_OR_F |=>
      irq_enable_o == ($past(flags_o[CRF_F_GIE])
                       | $past(operand_i[CRF_F_GIE]))
      && bank_sel_o == ($past(flags_o[CRF_F_BANK])
                        | $past(operand_i[CRF_F_BANK]));
  endproperty
  a_out: assert property (p_out)
    else $error("enable or bank output wrong");
  property p_eff;
    1'b1 |=> eff_addr_o == 8'($past(operand_i) + $past(index_o));
  endproperty
  a_eff: assert property (p_eff)
    else $error("indexed address wrong");
  property p_push;
    op_i == CRF_OP_PUSH |=> sp_o == 8'($past(sp_o) + 8'h01);
  endproperty
  a_push: assert property (p_push)
    else $error("push stack step wrong");
  property p_return_from_irq_op;
    op_i == CRF_OP_RETURN_FROM_IRQ_OP |=> sp_o == 8'($past(sp_o) - 8'h03);
  endproperty
  a_return_from_irq_op: assert property (p_return_from_irq_op)
    else $error("return stack step wrong");
  property p_swap;
    op_i == CRF_OP_SWAP_SP |=> sp_o == $past(acc_o) && acc_o == $past(sp_o);
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap wrong");
  property p_andf;
    op_i == CRF_OP_AND_F |=> (flags_o & CRF_FLAGS_WMASK)
      == ($past(flags_o) & $past(operand_i) & CRF_FLAGS_WMASK);
  endproperty
  a_andf: assert property (p_andf)
    else $error("and into flags wrong");
  property p_pc;
    pc_load_i |=> {pc_high_o, pc_low_o} == $past(pc_target_i);
  endproperty
  a_pc: assert property (p_pc)
    else $error("counter load wrong");
  c_hit: cover property (reg_addr_i == CRF_FLAGS_ADDR ##1 reg_hit_o);
  c_return_from_irq_op: cover property (op_i == CRF_OP_RETURN_FROM_IRQ_OP);
  c_swap: cover property (op_i == CRF_OP_SWAP_SP);
endmodule : crf_core_regs_asserts
bind crf_core_regs crf_core_regs_asserts #(
  .PC_WIDTH(PC_WIDTH), .PROG_BYTES(PROG_BYTES)
) i_crf_core_regs_asserts (
  .clk_i(clk_i), .reset_i(reset_i), .op_i(op_i), .operand_i(operand_i),
  .reg_addr_i(reg_addr_i), .super_i(super_i), .pc_load_i(pc_load_i),
  .pc_target_i(pc_target_i), .reg_rdata_o(reg_rdata_o),
  .reg_hit_o(reg_hit_o), .acc_o(acc_o), .index_o(index_o), .sp_o(sp_o),
  .pc_low_o(pc_low_o), .pc_high_o(pc_high_o), .flags_o(flags_o),
  .eff_addr_o(eff_addr_o), .irq_enable_o(irq_enable_o),
  .bank_sel_o(bank_sel_o)
);
`default_nettype wire

// ===== tb/cpu_core_register_file_tb.sv
// self-checking bench for the core register file
// assumes crf_pkg, the alu and the register file are compiled first
`timescale 1ns/1ns
`default_nettype none
module cpu_core_register_file_tb;
  import crf_pkg::*;
  logic        clk_i, reset_i, src_is_imm_i, pc_inc_i, pc_load_i, super_i;
  crf_op_e     op_i;
  crf_dst_e    dst_i;
  logic [2:0]  alu_func_i;
  logic [1:0]  pc_step_i, pst;
  logic [7:0]  operand_i, mem_data_i, reg_addr_i, reg_rdata_o, acc_o;
  logic [7:0]  index_o, sp_o, pc_low_o, pc_high_o, flags_o, eff_addr_o;
  logic        reg_hit_o, irq_enable_o, bank_sel_o, sup, ck, pl, pinc;
  logic [15:0] pc_target_i, epc, ptg;
  logic [7:0]  ea, ex, esp, ef;
  int          error_cnt = 0, checked = 0, cyc = 0;

  crf_core_regs i_crf_core_regs (
    .clk_i(clk_i), .reset_i(reset_i), .op_i(op_i), .dst_i(dst_i),
    .alu_func_i(alu_func_i), .src_is_imm_i(src_is_imm_i),
    .operand_i(operand_i), .mem_data_i(mem_data_i), .pc_inc_i(pc_inc_i),
    .pc_step_i(pc_step_i), .pc_load_i(pc_load_i),
    .pc_target_i(pc_target_i), .super_i(super_i), .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .acc_o(acc_o),
    .index_o(index_o), .sp_o(sp_o), .pc_low_o(pc_low_o),
    .pc_high_o(pc_high_o), .flags_o(flags_o), .eff_addr_o(eff_addr_o),
    .irq_enable_o(irq_enable_o), .bank_sel_o(bank_sel_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      $display("ERROR %0t run too long", $time);
      results();
    end
  end

  task automatic chk(logic [7:0] g, logic [7:0] e, logic [7:0] m);
    checked++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // returns {carry known, carry, result}; logic ops never carry, while
  // the borrow sense of sub is not pinned down, so it goes unchecked
  function automatic logic [9:0] alu(logic [2:0] f, logic [7:0] a, b);
    logic [8:0] s;
    case (f)
      3'h0: s = a + b;
      3'h1: s = a + b + 9'(ef[2]);
      3'h6: s = {a, 1'b0};
      3'h7: s = {a[0], ef[2], a[7:1]};
      3'h2: return {2'b00, 8'(a - b)};
      3'h3: return {2'b10, a & b};
      3'h4: return {2'b10, a | b};
      default: return {2'b10, a ^ b};
    endcase
    return {1'b1, s};
  endfunction : alu

  task automatic mres;
    {ea, ex, esp, epc} = 40'h0;
    ef = CRF_FLAGS_RESET;
    ck = 1'b1;
  endtask : mres

  // one operation, captured at the next edge, then every output is compared
  task automatic drv(crf_op_e o, crf_dst_e d, logic [2:0] f, logic imm,
                     logic [7:0] opd, logic [7:0] mem, logic [7:0] adr);
    logic [9:0] r;
    logic [7:0] b, erd, eea, fm, rdm;
    logic       hit;
    if (!ck && (f == 3'h1 || f == 3'h7)) f = 3'h0;
    @(posedge clk_i);
    op_i <= o;
    dst_i <= d;
    alu_func_i <= f;
    src_is_imm_i <= imm;
    operand_i <= opd;
    mem_data_i <= mem;
    reg_addr_i <= adr;
    super_i <= sup;
    pc_load_i <= pl;
    pc_inc_i <= pinc;
    pc_step_i <= pst;
    pc_target_i <= ptg;
    b = imm ? opd : mem;
    hit = adr == CRF_FLAGS_ADDR;
    rdm = ck ? 8'hFF : 8'hFB;
    erd = hit ? ef : 8'h00;
    eea = opd + ex;
    ef[3] = sup;
    case (o)
      CRF_OP_ALU: begin
        if (d != CRF_DST_F) begin
          r = alu(f, (d == CRF_DST_X) ? ex : (d == CRF_DST_SP) ? esp : ea, b);
          if (d == CRF_DST_X) ex = r[7:0];
          else if (d == CRF_DST_SP) esp = r[7:0];
          else ea = r[7:0];
          ef[1] = r[7:0] == 8'h00;
          ef[2] = r[8];
          ck = r[9];
        end
      end
      CRF_OP_LOAD: begin
        if (d == CRF_DST_X) ex = b;
        else if (d == CRF_DST_SP) esp = b;
        else if (d == CRF_DST_A) ea = b;
      end
      CRF_OP_POP: begin
        esp = esp - 8'h01;
        if (d == CRF_DST_X) ex = mem;
        else if (d == CRF_DST_A) ea = mem;
      end
      CRF_OP_OR_F: ef = ef | (opd & CRF_FLAGS_WMASK);
      CRF_OP_AND_F: ef = ef & (opd | ~CRF_FLAGS_WMASK);
      CRF_OP_XOR_F: ef = ef ^ (opd & CRF_FLAGS_WMASK);
      CRF_OP_PUSH: esp = esp + 8'h01;
      CRF_OP_CALL: esp = esp + 8'h02;
      CRF_OP_RET: esp = esp - 8'h02;
      CRF_OP_RETURN_FROM_IRQ_OP: begin
        esp = esp - 8'h03;
        ef = (ef & ~CRF_FLAGS_WMASK) | (mem & CRF_FLAGS_WMASK);
        ck = 1'b1;
      end
      CRF_OP_SWAP_SP: {ea, esp} = {esp, ea};
      CRF_OP_ADD_SP: esp = esp + opd;
      default: ;
    endcase
    if ((o == CRF_OP_OR_F && opd[2]) || (o == CRF_OP_AND_F && !opd[2]))
      ck = 1'b1;
    if (pl) epc = ptg;
    else if (pinc) epc = epc + 16'(pst);
    @(posedge clk_i);
    op_i <= CRF_OP_NONE;
    pc_load_i <= 1'b0;
    pc_inc_i <= 1'b0;
    #1;
    fm = ck ? 8'hFF : 8'hFB;
    chk(acc_o, ea, 8'hFF);
    chk(index_o, ex, 8'hFF);
    chk(sp_o, esp, 8'hFF);
    chk(pc_high_o, epc[15:8], 8'hFF);
    chk(pc_low_o, epc[7:0], 8'hFF);
    chk(flags_o, ef, fm);
    chk(eff_addr_o, eea, 8'hFF);
    chk({7'h00, reg_hit_o}, {7'h00, hit}, 8'h01);
    chk(reg_rdata_o, erd, rdm);
    chk({7'h00, irq_enable_o}, {7'h00, ef[0]}, 8'h01);
    chk({7'h00, bank_sel_o}, {7'h00, ef[4]}, 8'h01);
    pl = 1'b0;
    pinc = 1'b0;
  endtask : drv

  initial begin
    void'($urandom(35187));
    {reset_i, sup, pl, pinc, pst, ptg} = {4'b1000, 2'b01, 16'h0000};
    {src_is_imm_i, pc_inc_i, pc_load_i, super_i, pc_step_i} = 6'h00;
    {alu_func_i, operand_i, mem_data_i, reg_addr_i, pc_target_i} = 43'h0;
    op_i = CRF_OP_NONE;
    dst_i = CRF_DST_A;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    mres();
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00,
        CRF_FLAGS_ADDR);
    for (int i = 0; i < 8; i++)
      drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00,
          (i < 3) ? 8'(8'hF6 + 8'(i)) : 8'($urandom));
    $display("test reads done");
    drv(CRF_OP_POP, CRF_DST_X, 3'h0, 1'b1, 8'h00, 8'hA5, 8'h00);
    drv(CRF_OP_LOAD, CRF_DST_A, 3'h0, 1'b1, 8'h80, 8'h00, 8'h00);
    drv(CRF_OP_ALU, CRF_DST_A, 3'h0, 1'b1, 8'h80, 8'h00, 8'h00);
    drv(CRF_OP_ALU, CRF_DST_A, 3'h0, 1'b1, 8'h01, 8'h00, 8'h00);
    for (int i = 1; i < 13; i++)
      drv(crf_op_e'(i), CRF_DST_A, 3'(i), 1'b1, 8'($urandom), 8'($urandom),
          8'h00);
    drv(CRF_OP_ADD_SP, CRF_DST_A, 3'h0, 1'b1, 8'hFF, 8'h00, 8'h00);
    $display("test ops done");
    {pl, ptg} = {1'b1, 16'hFFFE};
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00);
    {pinc, pst} = {1'b1, 2'h3};
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00);
    {pl, pinc, ptg} = {2'b11, 16'h1FFF};
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00);
    $display("test counter done");
    for (int i = 0; i < 200; i++) begin
      {sup, pl, pinc, ptg} = 19'($urandom);
      pst = 2'($urandom_range(3, 1));
      drv(crf_op_e'($urandom_range(12)), crf_dst_e'($urandom_range(3)),
          3'($urandom), 1'($urandom), 8'($urandom), 8'($urandom),
          8'($urandom));
    end
    $display("test random done");
    sup = 1'b0;
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    mres();
    drv(CRF_OP_NONE, CRF_DST_A, 3'h0, 1'b1, 8'h00, 8'h00,
        CRF_FLAGS_ADDR);
    $display("test second reset done");
    results();
  end
endmodule : cpu_core_register_file_tb
`default_nettype wire
